// ### rtl/isa_cfg_pkg.sv
// Constants and carrier types for the ISA slot configuration and decode block
// Function
// - Compare host A9..A5 with five base straps; respond only on full match.
// - A strap in its off position reads as logic one, otherwise zero.
// - Inside the window, A4..A0 select the targeted internal register.
// - The window spans 32 consecutive bytes from the strap-selected base.
// - Default configuration: base 0x260, DMA channel 3, interrupt line 5.
// - DMA only on 8-bit channels 1, 2 or 3, one at a time.
// - No DMA over 16-bit channels; every request is 8-bit.
// - Request and acknowledge selections must name the same channel.
// - DMA disabled setting drives no request line; programmed I/O only.
// - Interrupt routes to exactly one of IRQ3, 4, 5, 6, 7 or 9.
// - Selected interrupt line driven tristate so others can share it.
// - Interrupt disabled setting never asserts any host interrupt line.
package isa_cfg_pkg;
    localparam int ADDR_W = 10;
    localparam int BASE_W = 5;
    localparam int OFS_W = 5;
    localparam int WINDOW_BYTES = 32;
    localparam int DMA_CH = 3;
    localparam int IRQ_LINES = 6;
    // Factory straps: base 0x260, DMA 3, IRQ5 (line code 3)
    localparam logic [4:0] BASE_DEFAULT = 5'h13;
    localparam logic [1:0] DMA_DEFAULT = 2'h3;
    localparam logic [1:0] DMA_OFF = 2'h0;
    localparam logic [2:0] IRQ_DEFAULT = 3'h3;
    localparam logic [2:0] IRQ_OFF = 3'h0;
    localparam logic [1:0] SETTLE_COUNT = 2'h3;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_CONFIG = 8'h0c;
    localparam logic [7:0] REG_ACCESS = 8'h10;
    // Control fields
    localparam int CTRL_DECODE_EN = 0;
    localparam int CTRL_DMA_REQ = 1;
    localparam logic CTRL_DECODE_RESET = 1'h1;
    // Status / mask fields
    localparam int ST_W = 4;
    localparam int ST_RD_HIT = 0;
    localparam int ST_WR_HIT = 1;
    localparam int ST_DMA_DONE = 2;
    localparam int ST_CFG_ERR = 3;
    localparam logic [3:0] MASK_RESET = 4'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic aen;
        logic ior_n;
        logic iow_n;
    } isa_bus_type;

    typedef struct packed {
        logic [BASE_W-1:0] base;
        logic [1:0] dma_req_sel;
        logic [1:0] dma_ack_sel;
        logic [2:0] irq_sel;
    } strap_type;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DATA = 1'b1
    } bus_state_type;
endpackage

// ### rtl/isa_slot_config_decode.sv
// ISA slot base decode, DMA channel and interrupt line routing, AHB-Lite registers
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module isa_slot_config_decode
    import isa_cfg_pkg::*;
(
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Strap pins, high for the off position
    input wire isa_cfg_pkg::strap_type strap_pins,
    // ISA host bus
    input wire isa_cfg_pkg::isa_bus_type isa_bus,
    input wire logic [2:0] dack_n,
    output logic [2:0] drq_out,
    output logic [2:0] drq_oe,
    output logic [5:0] irq_out,
    output logic [5:0] irq_oe,
    // Internal register select
    output logic io_hit,
    output logic io_hit_write,
    output logic [4:0] reg_sel,
    // Interrupt level
    output logic irq
);
    import isa_cfg_pkg::*;

    isa_bus_type bus_s1, bus_s2, bus_s3;
    strap_type strap_s1, strap_s2, cfg;
    logic [2:0] dack_s1, dack_s2;
    logic [1:0] settle;
    logic captured;
    logic decode_en;
    logic dma_pending;
    logic [ST_W-1:0] status, mask;
    logic [4:0] last_ofs;
    logic last_write;
    bus_state_type bus_state;
    logic [7:0] bus_addr;
    logic bus_write;

    function automatic logic [2:0] chan_onehot(input logic [1:0] ch);
        chan_onehot = 3'h0;
        if (ch != DMA_OFF)
            chan_onehot[ch - 2'h1] = 1'b1;
    endfunction

    // IRQ3,4,5,6,7,9 map to codes 1..6; 0 and 7 leave every line off
    function automatic logic [5:0] irq_onehot(input logic [2:0] code);
        irq_onehot = 6'h0;
        if (code != IRQ_OFF && code != 3'h7)
            irq_onehot[code - 3'h1] = 1'b1;
    endfunction

    // Pins pass two flops before use
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_s1 <= '{addr: '0, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
            bus_s2 <= '{addr: '0, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
            bus_s3 <= '{addr: '0, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
            strap_s1 <= '0;
            strap_s2 <= '0;
            dack_s1 <= 3'h7;
            dack_s2 <= 3'h7;
        end
        else if (ce)
        begin
            bus_s1 <= isa_bus;
            bus_s2 <= bus_s1;
            // Third stage only feeds the strobe edge detector
            bus_s3 <= bus_s2;
            strap_s1 <= strap_pins;
            strap_s2 <= strap_s1;
            dack_s1 <= dack_n;
            dack_s2 <= dack_s1;
        end
    end

    // Factory settings stand until the straps have settled through the synchroniser
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg <= '{base: BASE_DEFAULT, dma_req_sel: DMA_DEFAULT,
                     dma_ack_sel: DMA_DEFAULT, irq_sel: IRQ_DEFAULT};
            settle <= 2'h0;
            captured <= 1'b0;
        end
        else if (ce && !captured)
        begin
            if (settle == SETTLE_COUNT)
            begin
                cfg <= strap_s2;
                captured <= 1'b1;
            end
            else
                settle <= settle + 2'h1;
        end
    end

    logic [1:0] dma_ch;
    logic dma_valid, cfg_err;
    logic io_fall, io_match;
    logic [ADDR_W-1:0] base_addr;
    assign dma_ch = cfg.dma_req_sel;
    assign cfg_err = cfg.dma_req_sel != cfg.dma_ack_sel;
    assign dma_valid = !cfg_err && dma_ch != DMA_OFF;
    assign io_fall = (!bus_s2.ior_n && bus_s3.ior_n) || (!bus_s2.iow_n && bus_s3.iow_n);
    assign base_addr = {cfg.base, 5'h00};
    // Upper five bits alone decide, so the window is the 32 bytes above the base
    assign io_match = decode_en && !bus_s2.aen
        && bus_s2.addr[9:5] == cfg.base;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            io_hit <= 1'b0;
            io_hit_write <= 1'b0;
            reg_sel <= 5'h00;
        end
        else if (ce)
        begin
            io_hit <= io_fall && io_match;
            io_hit_write <= io_fall && io_match && !bus_s2.iow_n;
            if (io_fall && io_match)
                reg_sel <= bus_s2.addr[4:0];
        end
    end

    logic dma_ack;
    logic sw_dma_req;
    logic [ST_W-1:0] events, st_clear;
    assign dma_ack = dma_pending && dma_valid && (chan_onehot(dma_ch) & ~dack_s2) != 3'h0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dma_pending <= 1'b0;
        else if (ce)
        begin
            if (sw_dma_req && dma_valid)
                dma_pending <= 1'b1;
            else if (dma_ack || !dma_valid)
                dma_pending <= 1'b0;
        end
    end

    // Only the three 8-bit request lines exist; disabled or mismatched straps float them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            drq_out <= 3'h0;
            drq_oe <= 3'h0;
        end
        else if (ce)
        begin
            drq_oe <= dma_valid ? chan_onehot(dma_ch) : 3'h0;
            drq_out <= (dma_valid && dma_pending && !dma_ack) ? chan_onehot(dma_ch) : 3'h0;
        end
    end

    // Host placement of base, channel 2 and line 6 is left to software
    assign events[ST_RD_HIT] = io_fall && io_match && !bus_s2.ior_n;
    assign events[ST_WR_HIT] = io_fall && io_match && !bus_s2.iow_n;
    assign events[ST_DMA_DONE] = dma_ack;
    assign events[ST_CFG_ERR] = captured && cfg_err;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status <= '0;
        else if (ce)
            status <= (status & ~st_clear) | events;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            last_ofs <= 5'h00;
            last_write <= 1'b0;
        end
        else if (ce && io_fall && io_match)
        begin
            last_ofs <= bus_s2.addr[4:0];
            last_write <= !bus_s2.iow_n;
        end
    end

    // Drive only while asserting, so the line stays shareable
    logic irq_level;
    assign irq_level = (status & mask) != '0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq <= 1'b0;
            irq_out <= 6'h00;
            irq_oe <= 6'h00;
        end
        else if (ce)
        begin
            irq <= irq_level;
            irq_out <= irq_onehot(cfg.irq_sel);
            irq_oe <= irq_level ? irq_onehot(cfg.irq_sel) : 6'h00;
        end
    end

    // One wait state keeps hrdata straight from a flop
    logic bus_take, bus_wr_now;
    assign bus_take = hsel && htrans[1] && hready;
    assign bus_wr_now = ce && bus_state == BUS_DATA && bus_write;
    assign sw_dma_req = bus_wr_now && bus_addr == REG_CTRL && hwdata[CTRL_DMA_REQ];
    assign st_clear = (bus_wr_now && bus_addr == REG_STATUS) ? hwdata[ST_W-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_state <= BUS_IDLE;
            bus_addr <= 8'h00;
            bus_write <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0;
        end
        else if (ce)
        begin
            case (bus_state)
                BUS_IDLE:
                begin
                    if (bus_take)
                    begin
                        bus_state <= BUS_DATA;
                        bus_addr <= haddr[7:0];
                        bus_write <= hwrite;
                        hreadyout <= 1'b0;
                    end
                end
                BUS_DATA:
                begin
                    bus_state <= BUS_IDLE;
                    hreadyout <= 1'b1;
                    if (bus_write)
                        hrdata <= 32'h0;
                    else if (bus_addr == REG_CTRL)
                        hrdata <= {30'h0, dma_pending, decode_en};
                    else if (bus_addr == REG_STATUS)
                        hrdata <= {28'h0, status};
                    else if (bus_addr == REG_MASK)
                        hrdata <= {28'h0, mask};
                    else if (bus_addr == REG_CONFIG)
                        hrdata <= {19'h0, captured, cfg};
                    else if (bus_addr == REG_ACCESS)
                        hrdata <= {26'h0, last_write, last_ofs};
                    else
                        hrdata <= 32'h0;
                end
                default:
                    bus_state <= BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            decode_en <= CTRL_DECODE_RESET;
            mask <= MASK_RESET;
        end
        else if (bus_wr_now)
        begin
            if (bus_addr == REG_CTRL)
                decode_en <= hwdata[CTRL_DECODE_EN];
            else if (bus_addr == REG_MASK)
                mask <= hwdata[ST_W-1:0];
        end
    end

    // Always OKAY: no register access can fail
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresp <= 1'b0;
        else
            hresp <= 1'b0;
    end

    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_base_match_hit: assert property (ce && io_fall && io_match |=> io_hit && reg_sel == $past(bus_s2.addr[4:0]))
        else $error("matched io cycle did not hit");
    a_base_mismatch: assert property (ce && bus_s2.addr[9:5] != cfg.base |=> !io_hit)
        else $error("hit without base match");
    a_strap_capture: assert property (ce && !captured && settle == SETTLE_COUNT |=> cfg == $past(strap_s2))
        else $error("strap not captured as level");
    a_window_span: assert property (io_hit |-> $past(bus_s2.addr) - $past(base_addr) < 10'(WINDOW_BYTES))
        else $error("hit outside 32 byte window");
    a_default_cfg: assert property (!captured |-> cfg.base == BASE_DEFAULT && cfg.irq_sel == IRQ_DEFAULT && cfg.dma_req_sel == DMA_DEFAULT)
        else $error("default configuration wrong");
    a_one_dma_line: assert property ($onehot0(drq_oe) && (drq_out & ~drq_oe) == 3'h0)
        else $error("more than one dma line");
    a_dma_pair_off: assert property (ce && (cfg_err || dma_ch == DMA_OFF) |=> drq_oe == 3'h0)
        else $error("dma driven while disabled or mismatched");
    a_dma_off_pio: assert property (ce && !dma_valid |=> !dma_pending && drq_out == 3'h0)
        else $error("dma request while disabled");
    a_one_irq_line: assert property ($onehot0(irq_oe) && (irq_oe & ~irq_out) == 6'h00)
        else $error("irq on several lines");
    a_irq_tristate: assert property (ce && !irq_level |=> irq_oe == 6'h00)
        else $error("irq driven while idle");
    a_irq_disabled: assert property (ce && cfg.irq_sel == IRQ_OFF |=> irq_oe == 6'h00)
        else $error("irq driven while disabled");
    a_aen_ignored: assert property (ce && bus_s2.aen |=> !io_hit)
        else $error("hit during dma address enable");
    // A low enable must hold every decode result and sticky bit
    a_ce_freeze: assert property (!ce |=> $stable(reg_sel) && $stable(io_hit) && $stable(status))
        else $error("state moved while clock enable low");
    a_irq_follow: assert property (ce |=> irq == $past(irq_level))
        else $error("irq level does not follow status");
    a_dma_request: assert property (ce && sw_dma_req && dma_valid |=> dma_pending)
        else $error("dma request not taken");

    c_read_hit: cover property (io_hit && !io_hit_write);
    c_dma_done: cover property (dma_ack ##1 drq_out == 3'h0);
    c_irq_line: cover property (irq_oe != 6'h00);
    c_write_hit: cover property (io_hit && io_hit_write);
    c_cfg_error: cover property (status[ST_CFG_ERR]);
endmodule

// ### verification/isa_host_model.sv
// Host bus model: I/O cycles, DMA acknowledge and shared interrupt lines
`timescale 1ns/1ps
module isa_host_model
    import isa_cfg_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Card outputs
    input wire logic [2:0] drq_out,
    input wire logic [2:0] drq_oe,
    input wire logic [5:0] irq_out,
    input wire logic [5:0] irq_oe,
    // Acknowledge latency
    input wire logic [7:0] ack_delay,
    // Host drive
    output isa_cfg_pkg::isa_bus_type isa_bus,
    output logic [2:0] dack_n,
    output logic [5:0] irq_line
);
    import isa_cfg_pkg::*;

    int wait_cnt = 0;
    initial isa_bus = '{addr: 10'h0, aen: 1'b0, ior_n: 1'b1, iow_n: 1'b1};
    initial dack_n = 3'h7;
    // Released lines sit low on the host side
    assign irq_line = irq_oe & irq_out;
    task automatic io_cycle(input logic [9:0] a, input logic wr, input logic e);
        @(posedge hclk);
        isa_bus <= '{addr: a, aen: e, ior_n: 1'b1, iow_n: 1'b1};
        @(posedge hclk);
        isa_bus.ior_n <= wr;
        isa_bus.iow_n <= !wr;
        repeat (4) @(posedge hclk);
        // Address no longer valid once the strobe is gone
        isa_bus <= '{addr: ~a, aen: 1'b0, ior_n: 1'b1, iow_n: 1'b1};
        repeat (6) @(posedge hclk);
    endtask
    // Answer only the channel that requests, after a chosen delay
    always @(posedge hclk)
    begin
        if ((drq_out & drq_oe) == 3'h0)
        begin
            wait_cnt <= 0;
            dack_n <= 3'h7;
        end
        else if (wait_cnt < ack_delay)
            wait_cnt <= wait_cnt + 1;
        else
            dack_n <= ~(drq_out & drq_oe);
    end
endmodule

// ### verification/test_isa_slot_config_decode.sv
// Self-checking bench: strap settings, window decode, DMA and interrupt routing
`timescale 1ns/1ps
module test_isa_slot_config_decode;
    import isa_cfg_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic ce = 1'b1;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, io_hit, io_hit_write, irq;
    logic [31:0] hrdata, rd;
    strap_type strap_pins = '0;
    isa_bus_type isa_bus;
    logic [2:0] dack_n, drq_out, drq_oe;
    logic [5:0] irq_out, irq_oe, irq_line;
    logic [4:0] reg_sel;
    logic [7:0] ack_delay = 8'h0;
    logic last_wr = 1'b0;
    int err_count = 0;
    int checks = 0;
    int hits = 0;
    int drq_cnt = 0;
    // Bases kept within 0x100..0x3ff
    // Channel 2 and line 6 are never given to the card
    strap_type cfgs [8] = '{{5'h13, 2'h3, 2'h3, 3'h3}, {5'h08, 2'h1, 2'h1, 3'h1},
        {5'h1f, 2'h3, 2'h3, 3'h2}, {5'h0a, 2'h1, 2'h3, 3'h5}, {5'h15, 2'h0, 2'h0, 3'h5},
        {5'h11, 2'h3, 2'h3, 3'h6}, {5'h0c, 2'h1, 2'h1, 3'h0}, {5'h19, 2'h3, 2'h3, 3'h7}};
    initial forever #2.5 hclk = ~hclk;
    isa_slot_config_decode dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .strap_pins(strap_pins), .isa_bus(isa_bus), .dack_n(dack_n), .drq_out(drq_out),
        .drq_oe(drq_oe), .irq_out(irq_out), .irq_oe(irq_oe), .io_hit(io_hit),
        .io_hit_write(io_hit_write), .reg_sel(reg_sel), .irq(irq));
    isa_host_model host_u (.hclk(hclk), .drq_out(drq_out), .drq_oe(drq_oe),
        .irq_out(irq_out), .irq_oe(irq_oe), .ack_delay(ack_delay), .isa_bus(isa_bus),
        .dack_n(dack_n), .irq_line(irq_line));
    always @(posedge hclk)
    begin
        if (io_hit === 1'b1)
        begin
            hits <= hits + 1;
            last_wr <= io_hit_write;
        end
        if ((drq_out & drq_oe) != 3'h0)
            drq_cnt <= drq_cnt + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
        check(hresp, 1'b0);
    endtask
    // Address bit 0 picks read or write so both strobes get used
    task automatic io_expect(input logic [9:0] a, input logic e, input int n);
        int h;
        h = hits;
        host_u.io_cycle(a, a[0], e);
        repeat (4) @(posedge hclk);
        check(32'(hits - h), 32'(n));
        if (n == 1)
        begin
            check(reg_sel, a[4:0]);
            check(last_wr, a[0]);
        end
    endtask
    task automatic run_cfg(input strap_type s, input logic [7:0] dly);
        logic [9:0] base;
        logic [2:0] ch;
        logic [5:0] line;
        logic mis;
        int d;
        base = {s.base, 5'h00};
        mis = s.dma_req_sel != s.dma_ack_sel;
        ch = 3'h0;
        if (!mis && s.dma_req_sel != 2'h0)
            ch[s.dma_req_sel - 2'h1] = 1'b1;
        line = 6'h0;
        if (s.irq_sel != 3'h0 && s.irq_sel != 3'h7)
            line[s.irq_sel - 3'h1] = 1'b1;
        @(posedge hclk);
        hresetn <= 1'b0;
        strap_pins <= s;
        ack_delay <= dly;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        ahb(1'b0, REG_CONFIG, 32'h0);
        check(rd, {19'h0, 1'b1, s});
        ahb(1'b0, REG_CTRL, 32'h0);
        check(rd, 32'h1);
        ahb(1'b0, REG_MASK, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, REG_STATUS, 32'h0);
        check(rd, {28'h0, mis, 3'h0});
        ahb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0);
        check(drq_oe, ch);
        for (int i = 0; i < 3; i++)
            io_expect(base + 10'(5'($urandom)), 1'b0, 1);
        io_expect(base + 10'h1f, 1'b0, 1);
        io_expect(base - 10'h1, 1'b0, 0);
        io_expect(base + 10'h20, 1'b0, 0);
        io_expect(base + 10'h3, 1'b1, 0);
        // Frozen enable: a matching strobe must leave no trace
        ce <= 1'b0;
        io_expect(base + 10'h2, 1'b0, 0);
        ce <= 1'b1;
        for (int b = 5; b < 10; b++)
            io_expect(base ^ (10'h1 << b), 1'b0, 0);
        check(irq_oe, 6'h0);
        ahb(1'b1, REG_MASK, 32'h3);
        repeat (3) @(posedge hclk);
        check(irq, 1'b1);
        check(irq_oe, line);
        check(irq_out, line);
        check(irq_line, line);
        ahb(1'b1, REG_STATUS, 32'h3);
        repeat (3) @(posedge hclk);
        check(irq, 1'b0);
        check(irq_line, 6'h0);
        d = drq_cnt;
        ahb(1'b1, REG_CTRL, 32'h3);
        repeat (40 + dly) @(posedge hclk);
        check(drq_cnt > d, ch != 3'h0);
        check(drq_out, 3'h0);
        ahb(1'b0, REG_STATUS, 32'h0);
        check(rd[2], ch != 3'h0);
        ahb(1'b1, REG_CTRL, 32'h0);
        io_expect(base + 10'h4, 1'b0, 0);
    endtask
    initial
    begin
        void'($urandom(91152));
        for (int i = 0; i < 8; i++)
            run_cfg(cfgs[i], 8'(i * 5));
        complete_run();
    end
    // Each setting needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge hclk);
        err_count++;
        complete_run();
    end
endmodule
